// File: sbms_bus_model.sv
`timescale 1ns/1ps
// ------
// Bus engine model, echoes each byte
// ------
module sbms_bus_model #(
   parameter int DELAY = 10
) (
   input wire logic clk_sys_i,
   input wire logic byte_start_i,
   input wire logic [7:0] byte_out_i,
   output logic byte_done_o,
   output logic [7:0] byte_in_o
);
   int cnt = 0;
   logic [7:0] last = 8'h00;
   initial byte_done_o = 1'b0;
   initial byte_in_o = 8'hff;
   // Result only valid with done; inverse otherwise so stale data shows
   always @(posedge clk_sys_i) begin
      if (byte_start_i) begin
         last <= byte_out_i;
         cnt <= DELAY;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
      byte_done_o <= cnt == 1 && !byte_start_i;
      byte_in_o <= (cnt == 1 && !byte_start_i) ? last : ~last;
   end
endmodule

// File: sbms_chk.sv
`timescale 1ns/1ps
// ------
// Checker
// ------
module sbms_chk (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic rx_serial_i,
   input wire logic tx_serial_o,
   input wire logic bus_pullup_o,
   input wire logic prog_pulse_o,
   input wire logic byte_start_o,
   input wire logic [7:0] byte_out_o
);
   logic acc;
   logic [2:0] baud;
   logic [1:0] rc;
   assign acc = psel && penable;
   // Sync flops need two edges after reset
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         baud <= sbms_pkg::BAUD_RST;
         rc <= 2'h0;
      end else begin
         if (acc && pwrite && paddr == sbms_pkg::ADDR_CFG) baud <= pwdata[2:0];
         if (rc != 2'h3) rc <= rc + 2'h1;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   property p_pol; rc == 2'h3 |-> tx_serial_o == ($past(rx_serial_i, 2) ^ baud[2]); endproperty
   a_pol: assert property (p_pol) else $error("serial polarity wrong");
   property p_start; byte_start_o |=> !byte_start_o; endproperty
   a_start: assert property (p_start) else $error("byte start too long");
   property p_hold; byte_start_o |=> $stable(byte_out_o)[*3]; endproperty
   a_hold: assert property (p_hold) else $error("byte changed in flight");
   property p_pu_idle; bus_pullup_o |-> !byte_start_o; endproperty
   a_pu_idle: assert property (p_pu_idle) else $error("byte during pullup");
   property p_excl; !(bus_pullup_o && prog_pulse_o); endproperty
   a_excl: assert property (p_excl) else $error("pullup and pulse together");
   property p_term;
      acc && pwrite && paddr == sbms_pkg::ADDR_TXDATA && pwdata[7:0] == sbms_pkg::CMD_TERMINATE && prog_pulse_o
      |-> ##[1:4] !prog_pulse_o;
   endproperty
   a_term: assert property (p_term) else $error("pulse not ended");
   property p_rxd; acc && !pwrite && paddr == sbms_pkg::ADDR_RXDATA |-> prdata[31:9] == 23'h0; endproperty
   a_rxd: assert property (p_rxd) else $error("receive word malformed");
   property p_ctrl; acc && !pwrite && paddr == sbms_pkg::ADDR_CTRL |-> prdata[31:3] == 29'h0; endproperty
   a_ctrl: assert property (p_ctrl) else $error("control word malformed");
   c_pu: cover property ($rose(bus_pullup_o));
   c_pp: cover property ($fell(prog_pulse_o));
   c_rd: cover property (acc && paddr == sbms_pkg::ADDR_RXDATA && prdata[8]);
endmodule
bind sbms_top sbms_chk sbms_chk_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .rx_serial_i(rx_serial_i),
   .tx_serial_o(tx_serial_o), .bus_pullup_o(bus_pullup_o), .prog_pulse_o(prog_pulse_o),
   .byte_start_o(byte_start_o), .byte_out_o(byte_out_o));

// File: sbms_pkg.sv
package sbms_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TXDATA = 8'h08;
   localparam logic [7:0] ADDR_RXDATA = 8'h0c;
   localparam logic [7:0] ADDR_CFG = 8'h10;
   // ---------------------------------------------------------------
   // Host byte codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_SET_VPP_512 = 8'h29;
   localparam logic [7:0] ACK_VPP_512 = 8'h28;
   localparam logic [7:0] CMD_SET_SPU_524 = 8'h39;
   localparam logic [7:0] ACK_SPU_524 = 8'h38;
   localparam logic [7:0] CMD_ARM_PU = 8'hef;
   localparam logic [7:0] CMD_DISARM_PU = 8'hed;
   localparam logic [7:0] CMD_TERMINATE = 8'hf1;
   localparam logic [7:0] CMD_PROG_PULSE = 8'hfd;
   localparam logic [7:0] CMD_MODE_CMD = 8'he3;
   localparam logic [7:0] CMD_MODE_DATA = 8'he1;
   localparam logic [7:0] PULSE_RESP = 8'hfc;
   // ---------------------------------------------------------------
   // Times and cycle counts
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int VPP_512_US = 512;
   localparam int SPU_524_MS = 524;
   localparam int VPP_512_CYC = VPP_512_US * CLK_MHZ;
   localparam int SPU_524_CYC = SPU_524_MS * 1000 * CLK_MHZ;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [2:0] BAUD_RST = 3'h0;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 8;
   localparam int CNT_W = 32;
endpackage

// File: sbms_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Code 29 in command mode sets program pulse to 512us, answers 28.
// - Code 39 in command mode sets pullup duration to 524ms, answers 38.
// - Armed by EF, disarmed by ED; data byte, timed pullup, then pulse response.
// - Upper four baud value codes invert the serial receive-side output.
// - Armed and in data mode, strong pullup follows every byte.
// - F1 in command mode ends a running pulse silently, then the pulse response is sent.
// - One byte buffered while the previous executes; host must not overrun.
module sbms_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [AW:0] cnt, next_cnt;
   logic do_wr, do_rd;
   assign in_ready_o = (cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt != '0);
   assign out_data_o = mem[rp];
   assign do_wr = in_valid_i && in_ready_o;
   assign do_rd = out_valid_o && out_ready_i;
   always_comb begin
      next_wp = do_wr ? ((wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1) : wp;
      next_rp = do_rd ? ((rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1) : rp;
      next_cnt = cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   end
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
      if (do_wr) begin
         mem[wp] <= in_data_i;
      end
   end
endmodule

module sbms_top (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_serial_i,
   output logic tx_serial_o,
   output logic bus_pullup_o,
   output logic prog_pulse_o,
   output logic byte_start_o,
   output logic [7:0] byte_out_o,
   input wire logic byte_done_i,
   input wire logic [7:0] byte_in_i
);
   typedef enum logic [2:0] {
      SBMS_IDLE = 3'b000,
      SBMS_BYTE = 3'b001,
      SBMS_PULSE = 3'b010,
      SBMS_RESP = 3'b011
   } sbms_state_e;
   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   localparam int CNT_W = sbms_pkg::CNT_W;
   logic [2:0] baud, next_baud;
   logic [7:0] host_byte, next_host_byte;
   logic host_full, next_host_full;
   logic data_mode, next_data_mode;
   logic armed, next_armed;
   logic [CNT_W-1:0] vpp_cyc, next_vpp_cyc, spu_cyc, next_spu_cyc;
   logic [CNT_W-1:0] tmr, next_tmr;
   logic pu_on, next_pu_on, pp_on, next_pp_on;
   logic start, next_start;
   logic [7:0] obyte, next_obyte;
   logic rx_s1, rx_s2;
   sbms_state_e st, next_st;
   logic resp_valid, resp_ready;
   logic [7:0] resp_data;
   logic [7:0] f_data;
   logic f_valid, f_ready;
   logic wr_acc, rd_acc, take;
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign pslverr = psel && penable && (paddr > sbms_pkg::ADDR_CFG);
   always_comb begin
      prdata = 32'h0;
      unique case (paddr)
         sbms_pkg::ADDR_CTRL: prdata = {29'h0, armed, data_mode, host_full};
         sbms_pkg::ADDR_STATUS: prdata = {26'h0, f_valid, pu_on, pp_on, st};
         sbms_pkg::ADDR_RXDATA: prdata = {23'h0, f_valid, f_data};
         sbms_pkg::ADDR_CFG: prdata = {29'h0, baud};
         default: prdata = 32'h0;
      endcase
   end
   assign f_ready = rd_acc && (paddr == sbms_pkg::ADDR_RXDATA);
   // upper baud codes flip the receive-side output polarity
   assign tx_serial_o = rx_s2 ^ baud[2];
   always_ff @(posedge clk_sys_i) begin
      rx_s1 <= rx_serial_i;
      rx_s2 <= rx_s1;
   end
   // ---------------------------------------------------------------
   // Command interpreter
   // ---------------------------------------------------------------
   assign take = (st == SBMS_IDLE) && host_full && resp_ready;
   always_comb begin
      next_baud = baud;
      next_host_byte = host_byte;
      next_host_full = host_full;
      next_data_mode = data_mode;
      next_armed = armed;
      next_vpp_cyc = vpp_cyc;
      next_spu_cyc = spu_cyc;
      next_tmr = tmr;
      next_pu_on = pu_on;
      next_pp_on = pp_on;
      next_start = 1'b0;
      next_obyte = obyte;
      next_st = st;
      resp_valid = 1'b0;
      resp_data = 8'h0;
      if (wr_acc && paddr == sbms_pkg::ADDR_CFG) begin
         next_baud = pwdata[2:0];
      end
      // Single holding byte; a write while full is dropped (host pacing)
      if (wr_acc && paddr == sbms_pkg::ADDR_TXDATA && !host_full) begin
         next_host_byte = pwdata[7:0];
         next_host_full = 1'b1;
      end
      unique case (st)
         SBMS_IDLE: begin
            if (take) begin
               next_host_full = 1'b0;
               if (data_mode) begin
                  if (host_byte == sbms_pkg::CMD_MODE_CMD) begin
                     next_data_mode = 1'b0;
                  end else begin
                     next_obyte = host_byte;
                     next_start = 1'b1;
                     next_st = SBMS_BYTE;
                  end
               end else begin
                  unique case (host_byte)
                     sbms_pkg::CMD_MODE_DATA: next_data_mode = 1'b1;
                     sbms_pkg::CMD_SET_VPP_512: begin
                        next_vpp_cyc = CNT_W'(sbms_pkg::VPP_512_CYC);
                        resp_valid = 1'b1;
                        resp_data = sbms_pkg::ACK_VPP_512;
                     end
                     sbms_pkg::CMD_SET_SPU_524: begin
                        next_spu_cyc = CNT_W'(sbms_pkg::SPU_524_CYC);
                        resp_valid = 1'b1;
                        resp_data = sbms_pkg::ACK_SPU_524;
                     end
                     // Arm/disarm start a timed pullup the host can end early with F1
                     sbms_pkg::CMD_ARM_PU, sbms_pkg::CMD_DISARM_PU: begin
                        next_armed = (host_byte == sbms_pkg::CMD_ARM_PU);
                        next_pu_on = 1'b1;
                        next_tmr = spu_cyc;
                        next_st = SBMS_PULSE;
                     end
                     sbms_pkg::CMD_PROG_PULSE: begin
                        next_pp_on = 1'b1;
                        next_tmr = vpp_cyc;
                        next_st = SBMS_PULSE;
                     end
                     default: ;
                  endcase
               end
            end
         end
         SBMS_BYTE: begin
            if (byte_done_i) begin
               resp_valid = 1'b1;
               resp_data = byte_in_i;
               if (armed) begin
                  next_pu_on = 1'b1;
                  next_tmr = spu_cyc;
                  next_st = SBMS_PULSE;
               end else begin
                  next_st = SBMS_IDLE;
               end
            end
         end
         SBMS_PULSE: begin
            next_tmr = (tmr == '0) ? tmr : tmr - 1'b1;
            // Terminate: the F1 itself gets no answer
            if (host_full && host_byte == sbms_pkg::CMD_TERMINATE && !data_mode) begin
               next_host_full = 1'b0;
               next_st = SBMS_RESP;
            end else if (tmr == '0 || tmr == CNT_W'(1)) begin
               next_st = SBMS_RESP;
            end
            if (next_st == SBMS_RESP) begin
               next_pu_on = 1'b0;
               next_pp_on = 1'b0;
            end
         end
         SBMS_RESP: begin
            resp_valid = 1'b1;
            resp_data = sbms_pkg::PULSE_RESP;
            if (resp_ready) begin
               next_st = SBMS_IDLE;
            end
         end
         default: next_st = SBMS_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         baud <= sbms_pkg::BAUD_RST;
         host_byte <= 8'h0;
         host_full <= 1'b0;
         data_mode <= 1'b0;
         armed <= 1'b0;
         vpp_cyc <= CNT_W'(sbms_pkg::VPP_512_CYC);
         spu_cyc <= CNT_W'(sbms_pkg::SPU_524_CYC);
         tmr <= '0;
         pu_on <= 1'b0;
         pp_on <= 1'b0;
         start <= 1'b0;
         obyte <= 8'h0;
         st <= SBMS_IDLE;
      end else begin
         baud <= next_baud;
         host_byte <= next_host_byte;
         host_full <= next_host_full;
         data_mode <= next_data_mode;
         armed <= next_armed;
         vpp_cyc <= next_vpp_cyc;
         spu_cyc <= next_spu_cyc;
         tmr <= next_tmr;
         pu_on <= next_pu_on;
         pp_on <= next_pp_on;
         start <= next_start;
         obyte <= next_obyte;
         st <= next_st;
      end
   end
   assign bus_pullup_o = pu_on;
   assign prog_pulse_o = pp_on;
   assign byte_start_o = start;
   assign byte_out_o = obyte;
   // ---------------------------------------------------------------
   // Answer FIFO; a full FIFO stalls the interpreter
   // ---------------------------------------------------------------
   sbms_fifo #(
      .WIDTH(sbms_pkg::FIFO_WIDTH),
      .DEPTH(sbms_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .in_data_i(resp_data),
      .in_valid_i(resp_valid),
      .in_ready_o(resp_ready),
      .out_data_o(f_data),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready)
   );
endmodule

// File: test_serial_bus_master_sequencer.sv
`timescale 1ns/1ps
module test_serial_bus_master_sequencer;
   logic clk_sys_i = 1'b0, srst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_serial_i = 1'b1;
   logic [7:0] paddr = 8'h00, byte_out_o, byte_in_i;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, err, tx_serial_o, bus_pullup_o, prog_pulse_o, byte_start_o, byte_done_i;
   int n_errors = 0, cmp_count = 0, n_cyc = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   sbms_top sbms_top_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_serial_i(rx_serial_i),
      .tx_serial_o(tx_serial_o), .bus_pullup_o(bus_pullup_o), .prog_pulse_o(prog_pulse_o),
      .byte_start_o(byte_start_o), .byte_out_o(byte_out_o), .byte_done_i(byte_done_i), .byte_in_i(byte_in_i));
   sbms_bus_model #(.DELAY(10)) sbms_bus_model_inst (.clk_sys_i(clk_sys_i), .byte_start_i(byte_start_o),
      .byte_out_i(byte_out_o), .byte_done_o(byte_done_i), .byte_in_o(byte_in_i));
   task automatic wrap_up;
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic lim(input int n, input int m);
      if (n >= m) begin
         n_errors++;
         wrap_up();
      end
   endtask
   // Extra edge at the end keeps back-to-back calls off one time step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      lim(n, 50);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic hb(input logic [7:0] b);
      int n;
      n = 0;
      do begin
         xfer(1'b0, sbms_pkg::ADDR_CTRL, 32'h0);
         n++;
      end while (r[0] !== 1'b0 && n < 100);
      lim(n, 100);
      xfer(1'b1, sbms_pkg::ADDR_TXDATA, {24'h0, b});
   endtask
   task automatic rf(input logic [7:0] b);
      int n;
      n = 0;
      do begin
         xfer(1'b0, sbms_pkg::ADDR_RXDATA, 32'h0);
         n++;
      end while (r[8] !== 1'b1 && n < 200);
      chk(r, {23'h0, 1'b1, b});
      lim(n, 200);
   endtask
   task automatic rst;
      srst_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   initial begin
      rst();
      xfer(1'b0, sbms_pkg::ADDR_CTRL, 32'h0);
      chk(r, sbms_pkg::CTRL_RST);
      xfer(1'b0, sbms_pkg::ADDR_CFG, 32'h0);
      chk(r, {29'h0, sbms_pkg::BAUD_RST});
      xfer(1'b0, 8'h14, 32'h0);
      chk({r[30:0], err}, 32'h1);
      hb(sbms_pkg::CMD_SET_VPP_512);
      rf(sbms_pkg::ACK_VPP_512);
      hb(sbms_pkg::CMD_SET_SPU_524);
      rf(sbms_pkg::ACK_SPU_524);
      // Full-length program pulse, counted edge by edge
      hb(sbms_pkg::CMD_PROG_PULSE);
      @(posedge clk_sys_i);
      chk({31'h0, prog_pulse_o}, 32'h1);
      n_cyc = 0;
      do begin
         @(posedge clk_sys_i);
         n_cyc++;
      end while (prog_pulse_o === 1'b1 && n_cyc < 30000);
      lim(n_cyc, 30000);
      chk(32'(n_cyc), 32'(sbms_pkg::VPP_512_CYC));
      rf(sbms_pkg::PULSE_RESP);
      for (int i = 0; i < 16; i++) begin
         if (i[0] == 1'b0) xfer(1'b1, sbms_pkg::ADDR_CFG, 32'(i / 2));
         rx_serial_i <= i[0];
         repeat (4) @(posedge clk_sys_i);
         chk({31'h0, tx_serial_o}, {31'h0, i[0] ^ i[3]});
      end
      $display("config and polarity done");
      hb(sbms_pkg::CMD_PROG_PULSE);
      repeat (8) @(posedge clk_sys_i);
      chk({31'h0, prog_pulse_o}, 32'h1);
      xfer(1'b0, sbms_pkg::ADDR_STATUS, 32'h0);
      chk({29'h0, r[5:3]}, 32'h1);
      hb(sbms_pkg::CMD_TERMINATE);
      repeat (4) @(posedge clk_sys_i);
      chk({31'h0, prog_pulse_o}, 32'h0);
      rf(sbms_pkg::PULSE_RESP);
      xfer(1'b0, sbms_pkg::ADDR_RXDATA, 32'h0);
      chk({31'h0, r[8]}, 32'h0);
      $display("pulse end done");
      hb(sbms_pkg::CMD_MODE_DATA);
      hb(8'h5a);
      xfer(1'b1, sbms_pkg::ADDR_TXDATA, 32'hff);
      rf(8'h5a);
      rf(8'hff);
      hb(8'hff);
      rf(8'hff);
      hb(sbms_pkg::CMD_MODE_CMD);
      hb(sbms_pkg::CMD_PROG_PULSE);
      hb(sbms_pkg::CMD_TERMINATE);
      rf(sbms_pkg::PULSE_RESP);
      hb(sbms_pkg::CMD_MODE_DATA);
      hb(8'hff);
      rf(8'hff);
      $display("program sequence done");
      rst();
      hb(sbms_pkg::CMD_ARM_PU);
      repeat (8) @(posedge clk_sys_i);
      chk({31'h0, bus_pullup_o}, 32'h1);
      hb(sbms_pkg::CMD_TERMINATE);
      rf(sbms_pkg::PULSE_RESP);
      hb(sbms_pkg::CMD_MODE_DATA);
      hb(8'h44);
      rf(8'h44);
      chk({31'h0, bus_pullup_o}, 32'h1);
      xfer(1'b1, sbms_pkg::ADDR_TXDATA, 32'h55);
      xfer(1'b0, sbms_pkg::ADDR_CTRL, 32'h0);
      chk({29'h0, r[2:0]}, 32'h7);
      repeat (20) @(posedge clk_sys_i);
      xfer(1'b0, sbms_pkg::ADDR_RXDATA, 32'h0);
      chk({31'h0, r[8]}, 32'h0);
      rst();
      chk({30'h0, bus_pullup_o, prog_pulse_o}, 32'h0);
      $display("armed pullup done");
      wrap_up();
   end
endmodule
